// *** rtl/spio_pkg.sv ***
// Package for the six-bit I/O port with pin multiplexing.
// Shared by the port top, the pin cell and the request router; no assumptions.
package spio_pkg;

   localparam int          SPIO_ADDR_W        = 8;
   localparam int          SPIO_PINS          = 6;
   localparam int          SPIO_NBR_PINS      = 2;

   localparam logic [7:0]  SPIO_OFS_DIR       = 8'h00;
   localparam logic [7:0]  SPIO_OFS_DATA      = 8'h04;
   localparam logic [7:0]  SPIO_OFS_LEVEL     = 8'h08;
   localparam logic [7:0]  SPIO_OFS_CTRL      = 8'h0c;
   localparam logic [7:0]  SPIO_OFS_INTSEL    = 8'h10;
   localparam logic [7:0]  SPIO_OFS_XMODE     = 8'h14;
   localparam logic [7:0]  SPIO_OFS_NBR_DIR   = 8'h18;
   localparam logic [7:0]  SPIO_OFS_NBR_DATA  = 8'h1c;
   localparam logic [7:0]  SPIO_OFS_NBR_LEVEL = 8'h20;

   localparam logic [5:0]  SPIO_DIR_RST       = 6'h00;
   localparam logic [5:0]  SPIO_DATA_RST      = 6'h00;
   localparam logic [5:0]  SPIO_INTSEL_RST    = 6'h00;
   localparam logic [1:0]  SPIO_CTRL_RST      = 2'h0;
   localparam logic [3:0]  SPIO_XMODE_RST     = 4'h0;
   localparam logic [1:0]  SPIO_NBR_RST       = 2'h0;

   localparam int          SPIO_CTRL_EXPANSION_ENABLE     = 0;
   localparam int          SPIO_CTRL_DSEL     = 1;
   localparam int          SPIO_XM_ACK3       = 0;
   localparam int          SPIO_XM_ACK2       = 1;
   localparam int          SPIO_XM_END3       = 2;
   localparam int          SPIO_XM_END2       = 3;

   localparam logic [1:0]  SPIO_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  SPIO_RESP_SLVERR   = 2'h2;

endpackage : spio_pkg

// *** rtl/spio_pin_cell.sv ***
// One multiplexed pin: general I/O or an alternate output, plus interrupt tap.
// Assumes the pin level is synchronous to clk.
`timescale 1ns/1ps
module spio_pin_cell
   import spio_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic dirBit,
   input  wire logic dataBit,
   input  wire logic altEn,
   input  wire logic altVal,
   input  wire logic intSel,
   input  wire logic pinIn,
   output logic      pinOut_r,
   output logic      pinOe_r,
   output logic      intr_n_r
);
   wire logic pinOut_nxt;
   wire logic pinOe_nxt;
   wire logic intr_n_nxt;

   // Alternate output overrides the direction bit
   assign pinOut_nxt = altEn ? altVal : dataBit;
   assign pinOe_nxt  = altEn | dirBit;
   // Interrupt tap works alongside either direction
   assign intr_n_nxt = intSel ? pinIn : 1'b1;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pinOut_r <= 1'b0;
         pinOe_r  <= 1'b0;
         intr_n_r <= 1'b1;
      end else begin
         pinOut_r <= pinOut_nxt;
         pinOe_r  <= pinOe_nxt;
         intr_n_r <= intr_n_nxt;
      end
   end
endmodule : spio_pin_cell

// *** rtl/spio_req_route.sv ***
// Routes pin levels to the DMA request inputs of both DMA units.
// Assumes pin levels are synchronous to clk; requests are active low.
`timescale 1ns/1ps
module spio_req_route
   import spio_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [1:0] nbrPinIn,
   input  wire logic [1:0] portPinIn,
   input  wire logic       dmaUnitSelect,
   output logic [3:0]      xdmaRequest_n_r,
   output logic [1:0]      dmaRequest_n_r
);
   wire logic [3:0] xreq_nxt;
   wire logic [1:0] dreq_nxt;

   assign xreq_nxt = {portPinIn[1], portPinIn[0], nbrPinIn[1], nbrPinIn[0]};
   assign dreq_nxt = dmaUnitSelect ? nbrPinIn : 2'h3;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         xdmaRequest_n_r <= 4'hf;
         dmaRequest_n_r  <= 2'h3;
      end else begin
         xdmaRequest_n_r <= xreq_nxt;
         dmaRequest_n_r  <= dreq_nxt;
      end
   end
endmodule : spio_req_route

// *** rtl/spio_port.sv ***
// Six-bit multiplexed I/O port with two neighbouring-port pins, AXI4-Lite registers.
// Assumes pins and DMA strobes are synchronous to clk; pads resolve pin from out/oe.
//
// Notes on behaviour
// - Six bidirectional pins on bits 5..0, each with alternate functions.
// - Direction register is write-only; reads return zero, not the setting.
// - Direction bit 1 makes an output, 0 an input; resets to 0.
// - Bits 7 and 6 of direction and data read zero, ignore writes.
// - Output data register is read/write, resets zero, drives output pins.
// - Level readback gives data bit when output, pin level when input.
// - Level readback bits 7 and 6 are unspecified; here zero.
// - Expanded mode: pin 5 is channel 3 acknowledge when its ack-mode bit set.
// - Expanded mode: pin 4 is channel 2 acknowledge when its ack-mode bit set.
// - Expanded mode: pin 3 is channel 3 transfer-end when enable set.
// - Expansion disabled: pins 5..2 are plain general I/O only.
// - Interrupt select routes pin to active-low interrupt, alongside I/O use.
// - Neighbour pin 1 direction from its bit; always feeds external request 1.
// - Unit select gates neighbour pins to on-chip requests; pin 0 feeds request 0.
// - Expanded mode: pin 2 is channel 2 transfer-end when enable set.
// - Pins 1 and 0 are I/O feeding external requests 3 and 2.
`timescale 1ns/1ps
module spio_port
   import spio_pkg::*;
#(
   parameter int PINS = SPIO_PINS
)(
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic [SPIO_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [SPIO_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic [PINS-1:0]        pinIn,
   output logic [PINS-1:0]             pinOut,
   output logic [PINS-1:0]             pinOe,
   input  wire logic [1:0]             nbrPinIn,
   output logic [1:0]                  nbrPinOut,
   output logic [1:0]                  nbrPinOe,
   input  wire logic                   xdmaAckCh3,
   input  wire logic                   xdmaAckCh2,
   input  wire logic                   xdmaDoneCh3,
   input  wire logic                   xdmaDoneCh2,
   output logic [PINS-1:0]             extIntr_n,
   output logic [3:0]                  xdmaRequest_n,
   output logic [1:0]                  dmaRequest_n
);

   // Register state
   logic [PINS-1:0] pinDirection_r;
   logic [PINS-1:0] pinOutputData_r;
   logic [PINS-1:0] intPinSelect_r;
   logic [1:0]      ctrl_r;
   logic [3:0]      xdmaMode_r;
   logic [1:0]      nbrDir_r;
   logic [1:0]      nbrData_r;

   // Write channel state
   logic                   awHave_r;
   logic                   wHave_r;
   logic [SPIO_ADDR_W-1:0] awAddr_r;
   logic [31:0]            wData_r;
   logic [3:0]             wStrb_r;
   logic                   awReady_r;
   logic                   wReady_r;
   logic                   bValid_r;
   logic [1:0]             bResp_r;

   // Read channel state
   logic                   arReady_r;
   logic                   rValid_r;
   logic [31:0]            rData_r;
   logic [1:0]             rResp_r;

   // Write handshake decode
   wire logic awTake;
   wire logic wTake;
   wire logic doWrite;
   wire logic awHave_nxt;
   wire logic wHave_nxt;
   wire logic bValid_nxt;
   wire logic lane0;

   assign awTake     = s_axi_awvalid & awReady_r;
   assign wTake      = s_axi_wvalid & wReady_r;
   assign doWrite    = awHave_r & wHave_r & ~bValid_r;
   assign awHave_nxt = (awHave_r | awTake) & ~doWrite;
   assign wHave_nxt  = (wHave_r | wTake) & ~doWrite;
   assign bValid_nxt = doWrite | (bValid_r & ~s_axi_bready);
   assign lane0      = wStrb_r[0];

   // Write address decode
   wire logic wrDir;
   wire logic wrData;
   wire logic wrCtrl;
   wire logic wrIntSel;
   wire logic wrXMode;
   wire logic wrNbrDir;
   wire logic wrNbrData;
   wire logic wrRo;
   wire logic wrHit;

   assign wrDir     = doWrite & lane0 & (awAddr_r == SPIO_OFS_DIR);
   assign wrData    = doWrite & lane0 & (awAddr_r == SPIO_OFS_DATA);
   assign wrCtrl    = doWrite & lane0 & (awAddr_r == SPIO_OFS_CTRL);
   assign wrIntSel  = doWrite & lane0 & (awAddr_r == SPIO_OFS_INTSEL);
   assign wrXMode   = doWrite & lane0 & (awAddr_r == SPIO_OFS_XMODE);
   assign wrNbrDir  = doWrite & lane0 & (awAddr_r == SPIO_OFS_NBR_DIR);
   assign wrNbrData = doWrite & lane0 & (awAddr_r == SPIO_OFS_NBR_DATA);
   assign wrRo      = (awAddr_r == SPIO_OFS_LEVEL) | (awAddr_r == SPIO_OFS_NBR_LEVEL);
   assign wrHit     = wrRo | (awAddr_r == SPIO_OFS_DIR) | (awAddr_r == SPIO_OFS_DATA)
                    | (awAddr_r == SPIO_OFS_CTRL) | (awAddr_r == SPIO_OFS_INTSEL)
                    | (awAddr_r == SPIO_OFS_XMODE) | (awAddr_r == SPIO_OFS_NBR_DIR)
                    | (awAddr_r == SPIO_OFS_NBR_DATA);

   // Next register values; bits above the pins are dropped
   wire logic [PINS-1:0] pinDirection_nxt;
   wire logic [PINS-1:0] pinOutputData_nxt;
   wire logic [PINS-1:0] intPinSelect_nxt;
   wire logic [1:0]      ctrl_nxt;
   wire logic [3:0]      xdmaMode_nxt;
   wire logic [1:0]      nbrDir_nxt;
   wire logic [1:0]      nbrData_nxt;

   assign pinDirection_nxt  = wrDir     ? wData_r[PINS-1:0] : pinDirection_r;
   assign pinOutputData_nxt = wrData    ? wData_r[PINS-1:0] : pinOutputData_r;
   assign intPinSelect_nxt  = wrIntSel  ? wData_r[PINS-1:0] : intPinSelect_r;
   assign ctrl_nxt          = wrCtrl    ? wData_r[1:0]      : ctrl_r;
   assign xdmaMode_nxt      = wrXMode   ? wData_r[3:0]      : xdmaMode_r;
   assign nbrDir_nxt        = wrNbrDir  ? wData_r[1:0]      : nbrDir_r;
   assign nbrData_nxt       = wrNbrData ? wData_r[1:0]      : nbrData_r;

   // Mode decode
   wire logic expansionEnable;
   wire logic dmaUnitSelect;
   wire logic [PINS-1:0] altEn;
   wire logic [PINS-1:0] altVal;

   assign expansionEnable = ctrl_r[SPIO_CTRL_EXPANSION_ENABLE];
   assign dmaUnitSelect   = ctrl_r[SPIO_CTRL_DSEL];
   // Alternate DMA outputs exist only with expansion enabled
   assign altEn[5] = expansionEnable & xdmaMode_r[SPIO_XM_ACK3];
   assign altEn[4] = expansionEnable & xdmaMode_r[SPIO_XM_ACK2];
   assign altEn[3] = expansionEnable & xdmaMode_r[SPIO_XM_END3];
   assign altEn[2] = expansionEnable & xdmaMode_r[SPIO_XM_END2];
   assign altEn[1] = 1'b0;
   assign altEn[0] = 1'b0;
   assign altVal   = {xdmaAckCh3, xdmaAckCh2, xdmaDoneCh3, xdmaDoneCh2, 2'h0};

   // Level readback
   wire logic [PINS-1:0] pinLevel;
   wire logic [1:0]      nbrLevel;

   assign pinLevel = (pinDirection_r & pinOutputData_r) | (~pinDirection_r & pinIn);
   assign nbrLevel = (nbrDir_r & nbrData_r) | (~nbrDir_r & nbrPinIn);

   // Read decode; direction reads back zero, reserved bits zero
   wire logic        arTake;
   wire logic        rValid_nxt;
   wire logic [31:0] rdMux;
   wire logic        rdHit;

   assign arTake     = s_axi_arvalid & arReady_r;
   assign rValid_nxt = arTake | (rValid_r & ~s_axi_rready);
   assign rdHit      = (s_axi_araddr == SPIO_OFS_DIR) | (s_axi_araddr == SPIO_OFS_DATA)
                     | (s_axi_araddr == SPIO_OFS_LEVEL) | (s_axi_araddr == SPIO_OFS_CTRL)
                     | (s_axi_araddr == SPIO_OFS_INTSEL) | (s_axi_araddr == SPIO_OFS_XMODE)
                     | (s_axi_araddr == SPIO_OFS_NBR_DIR) | (s_axi_araddr == SPIO_OFS_NBR_DATA)
                     | (s_axi_araddr == SPIO_OFS_NBR_LEVEL);
   assign rdMux =
      (s_axi_araddr == SPIO_OFS_DATA)      ? {{(32-PINS){1'b0}}, pinOutputData_r} :
      (s_axi_araddr == SPIO_OFS_LEVEL)     ? {{(32-PINS){1'b0}}, pinLevel} :
      (s_axi_araddr == SPIO_OFS_CTRL)      ? {30'h0, ctrl_r} :
      (s_axi_araddr == SPIO_OFS_INTSEL)    ? {{(32-PINS){1'b0}}, intPinSelect_r} :
      (s_axi_araddr == SPIO_OFS_XMODE)     ? {28'h0, xdmaMode_r} :
      (s_axi_araddr == SPIO_OFS_NBR_DATA)  ? {30'h0, nbrData_r} :
      (s_axi_araddr == SPIO_OFS_NBR_LEVEL) ? {30'h0, nbrLevel} :
                                             32'h0;

   // Register file
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pinDirection_r  <= SPIO_DIR_RST;
         pinOutputData_r <= SPIO_DATA_RST;
         intPinSelect_r  <= SPIO_INTSEL_RST;
         ctrl_r          <= SPIO_CTRL_RST;
         xdmaMode_r      <= SPIO_XMODE_RST;
         nbrDir_r        <= SPIO_NBR_RST;
         nbrData_r       <= SPIO_NBR_RST;
      end else begin
         pinDirection_r  <= pinDirection_nxt;
         pinOutputData_r <= pinOutputData_nxt;
         intPinSelect_r  <= intPinSelect_nxt;
         ctrl_r          <= ctrl_nxt;
         xdmaMode_r      <= xdmaMode_nxt;
         nbrDir_r        <= nbrDir_nxt;
         nbrData_r       <= nbrData_nxt;
      end
   end

   // Write channels; address and data taken in either order
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         awHave_r  <= 1'b0;
         wHave_r   <= 1'b0;
         awAddr_r  <= '0;
         wData_r   <= 32'h0;
         wStrb_r   <= 4'h0;
         awReady_r <= 1'b0;
         wReady_r  <= 1'b0;
         bValid_r  <= 1'b0;
         bResp_r   <= SPIO_RESP_OKAY;
      end else begin
         awHave_r  <= awHave_nxt;
         wHave_r   <= wHave_nxt;
         awReady_r <= ~awHave_nxt;
         wReady_r  <= ~wHave_nxt;
         bValid_r  <= bValid_nxt;
         if (awTake) begin
            awAddr_r <= s_axi_awaddr;
         end
         if (wTake) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            bResp_r <= wrHit ? SPIO_RESP_OKAY : SPIO_RESP_SLVERR;
         end
      end
   end

   // Read channel
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         arReady_r <= 1'b0;
         rValid_r  <= 1'b0;
         rData_r   <= 32'h0;
         rResp_r   <= SPIO_RESP_OKAY;
      end else begin
         arReady_r <= ~rValid_nxt;
         rValid_r  <= rValid_nxt;
         if (arTake) begin
            rData_r <= rdMux;
            rResp_r <= rdHit ? SPIO_RESP_OKAY : SPIO_RESP_SLVERR;
         end
      end
   end

   assign s_axi_awready = awReady_r;
   assign s_axi_wready  = wReady_r;
   assign s_axi_bvalid  = bValid_r;
   assign s_axi_bresp   = bResp_r;
   assign s_axi_arready = arReady_r;
   assign s_axi_rvalid  = rValid_r;
   assign s_axi_rdata   = rData_r;
   assign s_axi_rresp   = rResp_r;

   // Port pins
   genvar g;
   generate
      for (g = 0; g < PINS; g = g + 1) begin : gPin
         spio_pin_cell uPin (
            .clk      (clk),
            .reset    (reset),
            .dirBit   (pinDirection_r[g]),
            .dataBit  (pinOutputData_r[g]),
            .altEn    (altEn[g]),
            .altVal   (altVal[g]),
            .intSel   (intPinSelect_r[g]),
            .pinIn    (pinIn[g]),
            .pinOut_r (pinOut[g]),
            .pinOe_r  (pinOe[g]),
            .intr_n_r (extIntr_n[g])
         );
      end
      // Neighbouring pins: direction bit alone, no alternate output
      for (g = 0; g < 2; g = g + 1) begin : gNbr
         spio_pin_cell uNbr (
            .clk      (clk),
            .reset    (reset),
            .dirBit   (nbrDir_r[g]),
            .dataBit  (nbrData_r[g]),
            .altEn    (1'b0),
            .altVal   (1'b0),
            .intSel   (1'b0),
            .pinIn    (nbrPinIn[g]),
            .pinOut_r (nbrPinOut[g]),
            .pinOe_r  (nbrPinOe[g]),
            .intr_n_r ()
         );
      end
   endgenerate

   // DMA request routing
   spio_req_route uReq (
      .clk             (clk),
      .reset           (reset),
      .nbrPinIn        (nbrPinIn),
      .portPinIn       (pinIn[1:0]),
      .dmaUnitSelect   (dmaUnitSelect),
      .xdmaRequest_n_r (xdmaRequest_n),
      .dmaRequest_n_r  (dmaRequest_n)
   );

endmodule : spio_port

// *** tb/spio_port_props.sv ***
// Checker of pin routing and bus timing for the six-bit port.
// Sees only the port top's ports; attached by bind below.
`timescale 1ns/1ps
module spio_port_chk
   import spio_pkg::*;
#(
   parameter int PINS = SPIO_PINS
)(
   input wire logic            clk,
   input wire logic            reset,
   input wire logic            s_axi_awvalid,
   input wire logic            s_axi_awready,
   input wire logic            s_axi_wvalid,
   input wire logic            s_axi_wready,
   input wire logic            s_axi_bvalid,
   input wire logic [31:0]     s_axi_rdata,
   input wire logic            s_axi_rvalid,
   input wire logic            s_axi_rready,
   input wire logic [PINS-1:0] pinIn,
   input wire logic [PINS-1:0] pinOut,
   input wire logic [PINS-1:0] pinOe,
   input wire logic [1:0]      nbrPinIn,
   input wire logic [PINS-1:0] extIntr_n,
   input wire logic [3:0]      xdmaRequest_n,
   input wire logic [1:0]      dmaRequest_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   AST_REQ_NBR: assert property (!$past(reset) |-> xdmaRequest_n[1:0] == $past(nbrPinIn))
      else $error("neighbour request mismatch");
   AST_REQ_PORT: assert property (!$past(reset) |-> xdmaRequest_n[3:2] == $past(pinIn[1:0]))
      else $error("port request mismatch");
   AST_DMA_REQ: assert property (!$past(reset) |-> dmaRequest_n == 2'h3 || dmaRequest_n == $past(nbrPinIn))
      else $error("on-chip request mismatch");
   AST_INTR: assert property ((~extIntr_n & $past(pinIn)) == '0)
      else $error("interrupt low while pin high");
   AST_RDATA: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == '0)
      else $error("read data upper bits set");
   AST_RST_IO: assert property ($fell(reset) |-> pinOe == '0 && pinOut == '0)
      else $error("pins driven after reset");
   AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
endmodule : spio_port_chk

bind spio_port spio_port_chk #(.PINS(PINS)) i_spio_port_chk (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pinIn, .pinOut,
   .pinOe, .nbrPinIn, .extIntr_n, .xdmaRequest_n, .dmaRequest_n);

// *** tb/spio_board.sv ***
// Board model: each pad follows the port when it drives, else the board.
// Assumes the board drives every released pad; no pulls.
`timescale 1ns/1ps
module spio_board
   import spio_pkg::*;
(
   input  wire logic [5:0] pinOut,
   input  wire logic [5:0] pinOe,
   input  wire logic [5:0] drvPin,
   input  wire logic [1:0] nbrPinOut,
   input  wire logic [1:0] nbrPinOe,
   input  wire logic [1:0] drvNbr,
   output logic [5:0]      pinIn,
   output logic [1:0]      nbrPinIn
);
   assign pinIn    = (pinOut & pinOe) | (drvPin & ~pinOe);
   assign nbrPinIn = (nbrPinOut & nbrPinOe) | (drvNbr & ~nbrPinOe);
endmodule : spio_board

// *** tb/tb_spio_port.sv ***
// Testbench of the six-bit port: AXI4-Lite tasks, board model, pin checks.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin nFail++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_spio_port
   import spio_pkg::*;
;
   logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [3:0] s_axi_wstrb, xdmaRequest_n;
   logic [1:0] s_axi_bresp, s_axi_rresp, nbrPinIn, nbrPinOut, nbrPinOe, drvNbr, dmaRequest_n;
   logic [5:0] pinIn, pinOut, pinOe, drvPin, extIntr_n;
   logic xdmaAckCh3, xdmaAckCh2, xdmaDoneCh3, xdmaDoneCh2;
   int nFail, cmpCount, i;

   spio_port i_spio_port (.clk, .reset, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pinIn, .pinOut, .pinOe, .nbrPinIn, .nbrPinOut, .nbrPinOe, .xdmaAckCh3,
      .xdmaAckCh2, .xdmaDoneCh3, .xdmaDoneCh2, .extIntr_n, .xdmaRequest_n, .dmaRequest_n);
   spio_board i_spio_board (.pinOut, .pinOe, .drvPin, .nbrPinOut, .nbrPinOe, .drvNbr, .pinIn, .nbrPinIn);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic wrapUp();
      $display("comparisons %0d mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrapUp

   task automatic tmo();
      nFail++;
      $display("wrong value handshake exp done got timeout");
      wrapUp();
   endtask : tmo

   task automatic settle();
      repeat (2) @(posedge clk);
   endtask : settle

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 40) tmo();
      `CHK("bresp", er, s_axi_bresp)
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      if (n == 40) tmo();
      `CHK("rdata", ed, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask : rd

   initial begin
      logic [7:0] ofs [7];
      ofs = '{SPIO_OFS_DIR, SPIO_OFS_DATA, SPIO_OFS_CTRL, SPIO_OFS_INTSEL, SPIO_OFS_XMODE,
              SPIO_OFS_NBR_DIR, SPIO_OFS_NBR_DATA};
      reset = 1'b1; s_axi_awaddr = 8'h00; s_axi_awprot = 3'h0; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf; s_axi_wvalid = 1'b0; s_axi_bready = 1'b1; s_axi_araddr = 8'h00;
      s_axi_arprot = 3'h0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; drvPin = 6'h00; drvNbr = 2'h0;
      xdmaAckCh3 = 1'b1; xdmaAckCh2 = 1'b1; xdmaDoneCh3 = 1'b1; xdmaDoneCh2 = 1'b1;
      nFail = 0; cmpCount = 0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 7; i++) rd(ofs[i], 32'h0, SPIO_RESP_OKAY);
      $display("test reset values done");
      wr(SPIO_OFS_DIR, 32'hff, SPIO_RESP_OKAY);
      wr(SPIO_OFS_DATA, 32'hff, SPIO_RESP_OKAY);
      rd(SPIO_OFS_DATA, 32'h3f, SPIO_RESP_OKAY);
      rd(SPIO_OFS_DIR, 32'h0, SPIO_RESP_OKAY);
      settle();
      `CHK("pinOe", 6'h3f, pinOe)
      `CHK("pinOut", 6'h3f, pinOut)
      wr(SPIO_OFS_DIR, 32'h0f, SPIO_RESP_OKAY);
      wr(SPIO_OFS_DATA, 32'h2a, SPIO_RESP_OKAY);
      drvPin <= 6'h15;
      wr(SPIO_OFS_LEVEL, 32'h3f, SPIO_RESP_OKAY);
      rd(SPIO_OFS_LEVEL, 32'h1a, SPIO_RESP_OKAY);
      `CHK("pinOe", 6'h0f, pinOe)
      s_axi_wstrb <= 4'he;
      wr(SPIO_OFS_DATA, 32'h15, SPIO_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(SPIO_OFS_DATA, 32'h2a, SPIO_RESP_OKAY);
      wr(8'h40, 32'h1, SPIO_RESP_SLVERR);
      rd(8'h40, 32'h0, SPIO_RESP_SLVERR);
      $display("test general io done");
      wr(SPIO_OFS_DIR, 32'h0, SPIO_RESP_OKAY);
      wr(SPIO_OFS_DATA, 32'h0, SPIO_RESP_OKAY);
      wr(SPIO_OFS_CTRL, 32'h1, SPIO_RESP_OKAY);
      for (i = 0; i < 4; i++) begin
         wr(SPIO_OFS_XMODE, 32'(1 << i), SPIO_RESP_OKAY);
         settle();
         `CHK("pinOe alt", 4'h8 >> i, pinOe[5:2])
         `CHK("pinOut alt", 4'h8 >> i, pinOut[5:2])
      end
      wr(SPIO_OFS_XMODE, 32'hf, SPIO_RESP_OKAY);
      xdmaAckCh2 <= 1'b0;
      xdmaDoneCh2 <= 1'b0;
      settle();
      `CHK("pinOut strobe", 4'ha, pinOut[5:2])
      rd(SPIO_OFS_DATA, 32'h0, SPIO_RESP_OKAY);
      wr(SPIO_OFS_CTRL, 32'h0, SPIO_RESP_OKAY);
      wr(SPIO_OFS_DIR, 32'h38, SPIO_RESP_OKAY);
      settle();
      `CHK("pinOe single chip", 6'h38, pinOe)
      `CHK("pinOut single chip", 3'h0, pinOut[5:3])
      $display("test alternate outputs done");
      wr(SPIO_OFS_DIR, 32'h20, SPIO_RESP_OKAY);
      wr(SPIO_OFS_DATA, 32'h20, SPIO_RESP_OKAY);
      drvPin <= 6'h05;
      drvNbr <= 2'h2;
      wr(SPIO_OFS_INTSEL, 32'h3f, SPIO_RESP_OKAY);
      settle();
      `CHK("extIntr_n", 6'h25, extIntr_n)
      `CHK("xdmaRequest_n", 4'h6, xdmaRequest_n)
      `CHK("dmaRequest_n", 2'h3, dmaRequest_n)
      wr(SPIO_OFS_INTSEL, 32'h38, SPIO_RESP_OKAY);
      wr(SPIO_OFS_CTRL, 32'h2, SPIO_RESP_OKAY);
      settle();
      `CHK("extIntr_n", 6'h27, extIntr_n)
      `CHK("dmaRequest_n", 2'h2, dmaRequest_n)
      wr(SPIO_OFS_NBR_DIR, 32'h1, SPIO_RESP_OKAY);
      wr(SPIO_OFS_NBR_DATA, 32'h1, SPIO_RESP_OKAY);
      settle();
      `CHK("nbrPinOe", 2'h1, nbrPinOe)
      `CHK("nbrPinOut", 2'h1, nbrPinOut)
      `CHK("xdmaRequest_n", 2'h3, xdmaRequest_n[1:0])
      rd(SPIO_OFS_NBR_LEVEL, 32'h3, SPIO_RESP_OKAY);
      $display("test interrupts and requests done");
      wrapUp();
   end
endmodule : tb_spio_port
